/* common/epc_pkg.sv */
package epc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] EPC_CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] EPC_STAT_OFFSET = 32'h0000_0004;
  localparam logic [7:0] EPC_CTRL_RESET = 8'h00;
  localparam int EPC_GO_BIT = 0;
  localparam int EPC_VSW_BIT = 1;
  localparam int EPC_ST_VPP_BIT = 0;
  localparam int EPC_ST_VON_BIT = 1;
  localparam int EPC_ST_PULSE_BIT = 2;
  localparam int EPC_ST_FUSE_BIT = 3;
  localparam int EPC_ST_LATCH_BIT = 4;
  localparam logic [1:0] EPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EPC_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int EPC_WORDS = 256;
  localparam int EPC_AW = 9;
  localparam int EPC_IW = 8;
  localparam logic [15:0] EPC_ERASED = 16'hFFFF;

  // ****************************************************************
  // Test port
  // ****************************************************************
  localparam logic [3:0] EPC_IR_BYPASS = 4'hF;
  localparam logic [3:0] EPC_IR_ADDR = 4'h3;
  localparam logic [3:0] EPC_IR_READ = 4'h4;
  localparam logic [3:0] EPC_IR_FUSE = 4'h9;
  localparam logic [3:0] EPC_IR_RESET = 4'hF;
  localparam int EPC_SYNC_W = 6;
endpackage : epc_pkg

/* src/epc_array.sv */
`timescale 1ns/1ns
module epc_array
  import epc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic core_req,
  input wire logic core_we,
  input wire logic core_word,
  input wire logic [EPC_AW-1:0] core_addr,
  input wire logic [15:0] core_wdata,
  output logic [15:0] core_rdata,
  output logic core_ack,
  input wire logic vpp_on,
  input wire logic pulse_on,
  input wire logic erase,
  input wire logic [EPC_AW-1:0] tp_addr,
  output logic [15:0] tp_rdata,
  output logic latch_full
);
  // ****************************************************************
  // Program latch
  // ****************************************************************
  logic [EPC_IW-1:0] lat_idx_reg, lat_idx_next;
  logic [15:0] lat_data_reg, lat_data_next;
  logic lat_full_reg, lat_full_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] tp_rdata_reg, tp_rdata_next;
  logic ack_reg, ack_next;
  logic [15:0] mem [EPC_WORDS];
  logic [EPC_IW-1:0] idx;
  logic [15:0] rd_word;

  assign idx = core_addr[EPC_AW-1:1];
  assign rd_word = mem[idx];

  always_comb begin
    lat_idx_next = lat_idx_reg;
    lat_data_next = lat_data_reg;
    lat_full_next = lat_full_reg;
    rdata_next = rdata_reg;
    ack_next = core_req;
    tp_rdata_next = mem[tp_addr[EPC_AW-1:1]];
    if (core_req && core_we && vpp_on) begin
      lat_idx_next = idx;
      lat_full_next = 1'b1;
      if (core_word) begin
        lat_data_next = core_wdata;
      end else if (core_addr[0]) begin
        lat_data_next = {core_wdata[7:0], 8'hFF};
      end else begin
        lat_data_next = {8'hFF, core_wdata[7:0]};
      end
    end
    if (core_req && !core_we) begin
      if (core_word) begin
        rdata_next = rd_word;
      end else if (core_addr[0]) begin
        rdata_next = {8'h00, rd_word[15:8]};
      end else begin
        rdata_next = {8'h00, rd_word[7:0]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lat_idx_reg <= '0;
      lat_data_reg <= EPC_ERASED;
      lat_full_reg <= 1'b0;
      rdata_reg <= '0;
      tp_rdata_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      lat_idx_reg <= lat_idx_next;
      lat_data_reg <= lat_data_next;
      lat_full_reg <= lat_full_next;
      rdata_reg <= rdata_next;
      tp_rdata_reg <= tp_rdata_next;
      ack_reg <= ack_next;
    end
  end

  // ****************************************************************
  // Cells: pulses only pull ones to zero, erase restores ones
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < EPC_WORDS; gi++) begin : g_cell
      always_ff @(posedge sys_clk) begin
        if (erase) begin
          mem[gi] <= EPC_ERASED;
        end else if (pulse_on && lat_full_reg &&
                     lat_idx_reg == EPC_IW'(gi)) begin
          mem[gi] <= mem[gi] & lat_data_reg;
        end
      end
    end
  endgenerate

  assign core_rdata = rdata_reg;
  assign core_ack = ack_reg;
  assign tp_rdata = tp_rdata_reg;
  assign latch_full = lat_full_reg;
endmodule : epc_array

/* src/epc_eprom_ctl.sv */
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
module epc_eprom_ctl
  import epc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core bus into the array
  input wire logic core_req,
  input wire logic core_we,
  input wire logic core_word,
  input wire logic [EPC_AW-1:0] core_addr,
  input wire logic [15:0] core_wdata,
  output logic [15:0] core_rdata,
  output logic core_ack,
  // Pins
  input wire logic vpp_present,
  input wire logic uv_erase,
  input wire logic fuse_sense,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic fuse_blow,
  output logic prog_voltage_on,
  output logic prog_pulse
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [EPC_SYNC_W-1:0] sync1_reg, sync2_reg;
  logic vpp_s, erase_s, fuse_s, tck_s, tms_s, tdi_s;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {vpp_present, uv_erase, fuse_sense, tck, tms, tdi};
      sync2_reg <= sync1_reg;
    end
  end

  assign {vpp_s, erase_s, fuse_s, tck_s, tms_s, tdi_s} = sync2_reg;

  // ****************************************************************
  // AXI4-Lite slave and registers
  // ****************************************************************
  logic [7:0] ctrl_reg, ctrl_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_take, rd_take;
  logic [7:0] status;
  logic volt_on, pulse_on, latch_full, fuse_blown;
  logic [EPC_AW-1:0] tp_addr;
  logic [15:0] tp_rdata;
  logic [3:0] tp_instr;

  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_take = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;

  assign status = {3'h0, latch_full, fuse_blown, pulse_on, volt_on, vpp_s};

  always_comb begin
    ctrl_next = ctrl_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (wr_take) begin
      bvalid_next = 1'b1;
      bresp_next = EPC_RESP_OKAY;
      if (s_axi_awaddr == EPC_CTRL_OFFSET) begin
        if (s_axi_wstrb[0]) begin
          ctrl_next = s_axi_wdata[7:0];
        end
      end else if (s_axi_awaddr != EPC_STAT_OFFSET) begin
        bresp_next = EPC_RESP_SLVERR;
      end
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next = EPC_RESP_OKAY;
      if (s_axi_araddr == EPC_CTRL_OFFSET) begin
        rdata_next = {24'h00_0000, ctrl_reg};
      end else if (s_axi_araddr == EPC_STAT_OFFSET) begin
        rdata_next = {24'h00_0000, status};
      end else begin
        rdata_next = '0;
        rresp_next = EPC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= EPC_CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= EPC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= EPC_RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // ****************************************************************
  // Programming voltage and pulse
  // ****************************************************************
  assign volt_on = ctrl_reg[EPC_VSW_BIT] && vpp_s;
  assign pulse_on = ctrl_reg[EPC_GO_BIT] && volt_on;
  assign prog_voltage_on = volt_on;
  assign prog_pulse = pulse_on;

  // ****************************************************************
  // Array and test port
  // ****************************************************************
  epc_array u_array (
    .sys_clk(sys_clk),
    .rst(rst),
    .core_req(core_req),
    .core_we(core_we),
    .core_word(core_word),
    .core_addr(core_addr),
    .core_wdata(core_wdata),
    .core_rdata(core_rdata),
    .core_ack(core_ack),
    .vpp_on(volt_on),
    .pulse_on(pulse_on),
    .erase(erase_s),
    .tp_addr(tp_addr),
    .tp_rdata(tp_rdata),
    .latch_full(latch_full)
  );

  epc_tport u_tport (
    .sys_clk(sys_clk),
    .rst(rst),
    .tck_s(tck_s),
    .tms_s(tms_s),
    .tdi_s(tdi_s),
    .fuse_sense_s(fuse_s),
    .tp_rdata(tp_rdata),
    .tp_addr(tp_addr),
    .tdo(tdo),
    .fuse_blow(fuse_blow),
    .fuse_blown(fuse_blown),
    .tp_instr(tp_instr)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  vpp_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !vpp_s |-> !prog_pulse && !prog_voltage_on)
    else $error("pulse or voltage without external supply");

  core_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    core_req && !core_we |=> core_ack)
    else $error("core read not answered next cycle");

  byte_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
    core_req && !core_we && !core_word |=> core_rdata[15:8] == 8'h00)
    else $error("byte read high lane not zero");

  go_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_take && s_axi_awaddr == EPC_CTRL_OFFSET && s_axi_wstrb[0] &&
    vpp_s ##1 vpp_s |-> prog_pulse ==
    ($past(s_axi_wdata[EPC_GO_BIT]) && $past(s_axi_wdata[EPC_VSW_BIT])))
    else $error("go bit does not start or end the pulse");

  volt_switch_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_take && s_axi_awaddr == EPC_CTRL_OFFSET && s_axi_wstrb[0] &&
    vpp_s ##1 vpp_s |->
    prog_voltage_on == $past(s_axi_wdata[EPC_VSW_BIT]))
    else $error("voltage switch bit not honoured");

  clear_both_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_take && s_axi_awaddr == EPC_CTRL_OFFSET && s_axi_wstrb[0] &&
    s_axi_wdata[1:0] == 2'b00 |=> !prog_pulse && !prog_voltage_on &&
    s_axi_bvalid)
    else $error("single write did not clear both bits");

  fuse_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    fuse_blown |=> fuse_blown [*4])
    else $error("fuse state reverted");

  fuse_bypass_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(fuse_blown) |-> tp_instr == EPC_IR_BYPASS)
    else $error("blown fuse left a non-bypass instruction");

  blow_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    fuse_blow |=> !fuse_blow && fuse_blown)
    else $error("fuse blow strobe longer than one cycle");

  write_resp_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");

  read_resp_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");

  stat_fuse_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_take && s_axi_araddr == EPC_STAT_OFFSET |=>
    s_axi_rdata[EPC_ST_FUSE_BIT] == $past(fuse_blown) &&
    s_axi_rdata[EPC_ST_VPP_BIT] == $past(vpp_s))
    else $error("status read does not show fuse or supply");

  unmapped_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_take && s_axi_araddr != EPC_CTRL_OFFSET &&
    s_axi_araddr != EPC_STAT_OFFSET |=> s_axi_rvalid &&
    s_axi_rresp == EPC_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : epc_eprom_ctl

/* src/epc_tport.sv */
`timescale 1ns/1ns
module epc_tport
  import epc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck_s,
  input wire logic tms_s,
  input wire logic tdi_s,
  input wire logic fuse_sense_s,
  input wire logic [15:0] tp_rdata,
  output logic [EPC_AW-1:0] tp_addr,
  output logic tdo,
  output logic fuse_blow,
  output logic fuse_blown,
  output logic [3:0] tp_instr
);
  logic tck_d_reg, tck_d_next;
  logic tms_d_reg, tms_d_next;
  logic [3:0] irs_reg, irs_next;
  logic [3:0] ir_reg, ir_next;
  logic [15:0] dr_reg, dr_next;
  logic byp_reg, byp_next;
  logic tdo_reg, tdo_next;
  logic fuse_reg, fuse_next;
  logic blow_reg, blow_next;
  logic [EPC_AW-1:0] addr_reg, addr_next;
  logic tck_rise;

  assign tck_rise = tck_s && !tck_d_reg;

  always_comb begin
    tck_d_next = tck_s;
    tms_d_next = tms_d_reg;
    irs_next = irs_reg;
    ir_next = ir_reg;
    dr_next = dr_reg;
    byp_next = byp_reg;
    tdo_next = tdo_reg;
    addr_next = addr_reg;
    blow_next = 1'b0;
    fuse_next = fuse_reg | fuse_sense_s;
    if (tck_rise) begin
      tms_d_next = tms_s;
      if (tms_s) begin
        irs_next = {tdi_s, irs_reg[3:1]};
        if (!tms_d_reg && ir_reg == EPC_IR_ADDR && !fuse_reg) begin
          addr_next = dr_reg[EPC_AW-1:0];
        end
      end else if (tms_d_reg) begin
        // Instruction update on leaving instruction shift
        ir_next = fuse_reg ? EPC_IR_BYPASS : irs_reg;
        if (irs_reg == EPC_IR_FUSE && !fuse_reg) begin
          fuse_next = 1'b1;
          blow_next = 1'b1;
        end
        if (irs_reg == EPC_IR_READ && !fuse_reg) begin
          dr_next = tp_rdata;
        end
      end else if (ir_reg == EPC_IR_ADDR || ir_reg == EPC_IR_READ) begin
        dr_next = {tdi_s, dr_reg[15:1]};
        tdo_next = dr_reg[0];
      end else begin
        byp_next = tdi_s;
        tdo_next = byp_reg;
      end
    end
    if (fuse_reg) begin
      ir_next = EPC_IR_BYPASS;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tck_d_reg <= 1'b0;
      tms_d_reg <= 1'b0;
      irs_reg <= EPC_IR_RESET;
      ir_reg <= EPC_IR_RESET;
      dr_reg <= '0;
      byp_reg <= 1'b0;
      tdo_reg <= 1'b0;
      fuse_reg <= 1'b0;
      blow_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      tck_d_reg <= tck_d_next;
      tms_d_reg <= tms_d_next;
      irs_reg <= irs_next;
      ir_reg <= ir_next;
      dr_reg <= dr_next;
      byp_reg <= byp_next;
      tdo_reg <= tdo_next;
      fuse_reg <= fuse_next;
      blow_reg <= blow_next;
      addr_reg <= addr_next;
    end
  end

  assign tp_addr = addr_reg;
  assign tdo = tdo_reg;
  assign fuse_blow = blow_reg;
  assign fuse_blown = fuse_reg;
  assign tp_instr = ir_reg;

  bypass_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    tck_rise && fuse_reg && !tms_s && !tms_d_reg |=> tdo == $past(byp_reg))
    else $error("bypass path lost");
endmodule : epc_tport

/* verif/epc_core_model.sv */
`timescale 1ns/1ns
module epc_core_model
  import epc_pkg::*;
(
  input wire logic sys_clk,
  output logic core_req,
  output logic core_we,
  output logic core_word,
  output logic [EPC_AW-1:0] core_addr,
  output logic [15:0] core_wdata,
  input wire logic [15:0] core_rdata,
  input wire logic core_ack
);
  initial begin
    core_req = 1'b0;
    core_we = 1'b0;
    core_word = 1'b0;
    core_addr = '0;
    core_wdata = 16'h0000;
  end

  // ******************************************
  // One access: request pulse, wait for ack
  // ******************************************
  task automatic access(input logic we, input logic word,
    input logic [EPC_AW-1:0] addr, input logic [15:0] wdata,
    output logic [15:0] rdata);
    int n;
    @(posedge sys_clk);
    core_req <= 1'b1;
    core_we <= we;
    core_word <= word;
    core_addr <= addr;
    core_wdata <= wdata;
    @(posedge sys_clk);
    core_req <= 1'b0;
    n = 0;
    while (core_ack !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    rdata = core_rdata;
    // Released lines show garbage
    core_addr <= ~addr;
    core_wdata <= ~wdata;
  endtask : access
endmodule : epc_core_model

/* verif/eprom_program_control_bench.sv */
`timescale 1ns/1ns
module eprom_program_control_bench;
  import epc_pkg::*;
  localparam int PRIME = 1000;
  localparam int MAX_TRY = 25;
  localparam logic [31:0] BAD_ADDR = 32'h0000_0008;
  logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic core_req, core_we, core_word, core_ack;
  logic [EPC_AW-1:0] core_addr;
  logic [15:0] core_wdata, core_rdata;
  logic vpp_present, uv_erase, fuse_sense, tck, tms, tdi, tdo;
  logic fuse_blow, prog_voltage_on, prog_pulse;
  logic [31:0] st = 32'h3b72_479c;
  int err_count = 0;
  int total_checks = 0;
  int blow_count = 0;

  epc_eprom_ctl i_dut (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_req(core_req), .core_we(core_we),
    .core_word(core_word), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata),
    .core_ack(core_ack), .vpp_present(vpp_present),
    .uv_erase(uv_erase), .fuse_sense(fuse_sense), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .fuse_blow(fuse_blow),
    .prog_voltage_on(prog_voltage_on), .prog_pulse(prog_pulse));

  epc_core_model i_core (.sys_clk(sys_clk), .core_req(core_req),
    .core_we(core_we), .core_word(core_word), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata),
    .core_ack(core_ack));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (fuse_blow === 1'b1) blow_count <= blow_count + 1;
  end

  // ******************************************
  // Helpers
  // ******************************************
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : rnd

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_test(input string name);
    $display("test %s finished, %0d mismatches", name, err_count);
  endtask : end_test

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1 && !awvalid && !wvalid));
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1 && !arvalid));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Software fast algorithm
  task automatic burn(input logic word, input logic [EPC_AW-1:0] a,
    input logic [15:0] d, output int tries);
    logic [15:0] rd;
    logic [15:0] want;
    logic [1:0] r;
    want = word ? d : {8'h00, d[7:0]};
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0002, r);
    tries = 0;
    do begin
      tries++;
      i_core.access(1'b1, word, a, d, rd);
      axi_wr(EPC_CTRL_OFFSET, 32'h0000_0003, r);
      chk("prog_pulse", 32'h1, 32'(prog_pulse));
      repeat (PRIME) @(posedge sys_clk);
      axi_wr(EPC_CTRL_OFFSET, 32'h0000_0002, r);
      i_core.access(1'b0, word, a, 16'h0000, rd);
    end while (rd !== want && tries < MAX_TRY);
    if (rd === want) begin
      i_core.access(1'b1, word, a, d, rd);
      axi_wr(EPC_CTRL_OFFSET, 32'h0000_0003, r);
      repeat (3 * tries * PRIME) @(posedge sys_clk);
    end else tries = MAX_TRY + 1;
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0000, r);
    chk("prog_voltage_on", 32'h0, 32'(prog_voltage_on));
    chk("prog_pulse", 32'h0, 32'(prog_pulse));
  endtask : burn

  task automatic tap(input logic ms, input logic di);
    tms <= ms;
    tdi <= di;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b1;
    repeat (5) @(posedge sys_clk);
    tck <= 1'b0;
  endtask : tap

  task automatic shift_ir(input logic [3:0] code);
    for (int i = 0; i < 4; i++) tap(1'b1, code[i]);
    tap(1'b0, 1'b0);
  endtask : shift_ir

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    $display("unexpected run time: expected end seen still running");
    print_verdict();
  end

  // ******************************************
  // Main sequence
  // ******************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] rd, w1;
    logic [EPC_AW-1:0] a1, a2;
    logic [7:0] b;
    logic prev;
    int tries;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    {vpp_present, uv_erase, fuse_sense, tck, tms, tdi} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(EPC_CTRL_OFFSET, d, r);
    chk("ctrl reset", 32'(EPC_CTRL_RESET), d);
    chk("ctrl rresp", 32'(EPC_RESP_OKAY), 32'(r));
    axi_rd(EPC_STAT_OFFSET, d, r);
    chk("stat reset", 32'h0, d);
    axi_rd(BAD_ADDR, d, r);
    chk("bad rresp", 32'(EPC_RESP_SLVERR), 32'(r));
    chk("bad rdata", 32'h0, d);
    axi_wr(BAD_ADDR, st, r);
    chk("bad bresp", 32'(EPC_RESP_SLVERR), 32'(r));
    st = rnd(st);
    axi_wr(EPC_CTRL_OFFSET, st, r);
    axi_rd(EPC_CTRL_OFFSET, d, r);
    chk("ctrl rw", {24'h00_0000, st[7:0]}, d);
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0000, r);
    end_test("registers");
    uv_erase <= 1'b1;
    repeat (6) @(posedge sys_clk);
    uv_erase <= 1'b0;
    repeat (4) @(posedge sys_clk);
    st = rnd(st);
    a1 = {st[7:0], 1'b0};
    a2 = {~st[7], st[6:0], 1'b0};
    w1 = st[23:8] & 16'h7fff;
    b = st[31:24];
    i_core.access(1'b0, 1'b1, a1, 16'h0000, rd);
    chk("erased word", 32'h0000_ffff, 32'(rd));
    i_core.access(1'b0, 1'b0, a1 | 9'h001, 16'h0000, rd);
    chk("erased byte", 32'h0000_00ff, 32'(rd));
    end_test("erase");
    vpp_present <= 1'b1;
    repeat (4) @(posedge sys_clk);
    burn(1'b1, a1, w1, tries);
    chk("word burn ok", 32'h1, 32'(tries <= MAX_TRY));
    i_core.access(1'b0, 1'b1, a1, 16'h0000, rd);
    chk("word read", 32'(w1), 32'(rd));
    i_core.access(1'b0, 1'b0, a1, 16'h0000, rd);
    chk("low byte", 32'(w1[7:0]), 32'(rd));
    i_core.access(1'b0, 1'b0, a1 | 9'h001, 16'h0000, rd);
    chk("high byte", 32'(w1[15:8]), 32'(rd));
    burn(1'b0, a2 | 9'h001, {8'h00, b}, tries);
    i_core.access(1'b0, 1'b1, a2, 16'h0000, rd);
    chk("byte burn", 32'({b, 8'hff}), 32'(rd));
    end_test("program");
    burn(1'b1, a1, 16'hffff, tries);
    chk("burn fails", 32'(MAX_TRY + 1), 32'(tries));
    i_core.access(1'b0, 1'b1, a1, 16'h0000, rd);
    chk("no 0 to 1", 32'(w1), 32'(rd));
    end_test("refuse");
    vpp_present <= 1'b0;
    repeat (4) @(posedge sys_clk);
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0003, r);
    chk("vsw no vpp", 32'h0, 32'(prog_voltage_on));
    i_core.access(1'b1, 1'b1, a1, 16'h0000, rd);
    repeat (20) @(posedge sys_clk);
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0000, r);
    i_core.access(1'b0, 1'b1, a1, 16'h0000, rd);
    chk("write no vpp", 32'(w1), 32'(rd));
    vpp_present <= 1'b1;
    repeat (4) @(posedge sys_clk);
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0002, r);
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0003, r);
    repeat (20) @(posedge sys_clk);
    axi_wr(EPC_CTRL_OFFSET, 32'h0000_0000, r);
    i_core.access(1'b0, 1'b1, a1, 16'h0000, rd);
    chk("latch no vpp", 32'(w1), 32'(rd));
    end_test("no voltage");
    shift_ir(EPC_IR_FUSE);
    repeat (4) @(posedge sys_clk);
    chk("fuse_blow pulses", 32'h1, 32'(blow_count));
    fuse_sense <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    axi_rd(EPC_STAT_OFFSET, d, r);
    chk("fuse kept", 32'h1, 32'(d[EPC_ST_FUSE_BIT]));
    shift_ir(EPC_IR_READ);
    prev = 1'b0;
    for (int i = 0; i < 10; i++) begin
      st = rnd(st);
      tap(1'b0, st[0]);
      if (i > 0) chk("bypass tdo", 32'(prev), 32'(tdo));
      prev = st[0];
    end
    end_test("fuse");
    print_verdict();
  end
endmodule : eprom_program_control_bench
